//--- common/aux_mux_pkg.sv
// shared constants and types for the auxiliary pin function multiplexer
package aux_mux_pkg;

  // per-pin function codes held in configuration memory
  typedef enum logic [3:0] {
    FN_PULLED_UP_INPUT = 4'h0,
    FN_LINE_DRV_EN     = 4'h1,
    FN_POWER_EN_N      = 4'h2,
    FN_TX_LED_N        = 4'h3,
    FN_RX_LED_N        = 4'h4,
    FN_TXRX_LED_N      = 4'h5,
    FN_SUSPEND_N       = 4'h6,
    FN_CLK_FAST        = 4'h7,
    FN_CLK_MID         = 4'h8,
    FN_CLK_SLOW        = 4'h9,
    FN_DRIVE_HIGH      = 4'ha,
    FN_DRIVE_LOW       = 4'hb,
    FN_BITBANG         = 4'hc
  } pin_fn_t;

  localparam int          CTRL_PINS     = 10;
  localparam int          DATA_PINS     = 8;
  localparam int          FN_BITS       = 4;
  // pin numbers that carry clock and drive-high, bit-bang and common options
  localparam logic [9:0]  CLK_PIN_MASK  = 10'h361;
  localparam logic [9:0]  BB_PIN_MASK   = 10'h360;
  localparam logic [9:0]  ANY_PIN_MASK  = 10'h37f;
  localparam logic [3:0]  CFG_RESET_FN  = 4'h0;
  // clock and timing figures
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          WAKE_MS       = 20;
  localparam int          WAKE_CYCLES   = (CLK_HZ / 1000) * WAKE_MS + 1;
  localparam int          LED_MS        = 25;
  localparam int          LED_CYCLES    = (CLK_HZ / 1000) * LED_MS;

  // status of the bridge that the mux consumes
  typedef struct packed {
    logic configured;  // usb host configured the device
    logic suspended;   // usb suspend
    logic tx_busy;     // serial engine shifting a frame
    logic tx_guard;    // frame plus one bit before and after
    logic rx_busy;     // receiver taking a frame
  } link_state_t;

  // three signals of one two-way pin
  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_down;
  } pin_drive_t;

endpackage : aux_mux_pkg

//--- rtl/activity_stretch.sv
// one-shot low pulse stretcher for activity indicators
`timescale 1ns/1ps
`default_nettype none
module activity_stretch
  import aux_mux_pkg::*;
#(
  parameter int HOLD = LED_CYCLES  // pulse length in clk cycles
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic busy_i,   // activity level
  output logic      led_n_o   // low pulse
);
  // a zero hold would never light the indicator
  if (HOLD < 1) begin : g_bad_hold
    $error("activity_stretch: HOLD must be at least one");
  end

  logic [31:0] cnt_reg;   // remaining low time
  logic [31:0] cnt_next;

  // retrigger while busy so a stream shows a steady low
  always_comb begin
    cnt_next = cnt_reg;
    if (busy_i) begin
      cnt_next = 32'(HOLD);
    end else if (cnt_reg != 32'h0) begin
      cnt_next = cnt_reg - 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign led_n_o = (cnt_reg == 32'h0);
endmodule // activity_stretch
`default_nettype wire

//--- rtl/aux_pin_function_mux.sv
// auxiliary control-bus and data-bus pin function multiplexer
//
// Behaviour
// [R1] driver enable spans frame plus one bit
// [R2] power enable low configured, high suspended
// [R3] transmit led pulses low while sending
// [R4] receive led pulses low while receiving
// [R5] combined led pulses on either direction
// [R6] suspend indicator low during usb suspend
// [R7] clock outputs only on pins 0,5,6,8,9
// [R8] bit-bang only on pins 5,6,8,9
// [R9] common options everywhere except pin 7
// [R10] functions loaded from configuration at startup
// [R11] data pins default to serial port
// [R12] ring low over 20 ms wakes host
// [R13] inputs pulled up, optionally down in suspend
// [R14] use pull-down option with power enable
// [R15] fixed levels; drive-high only clock pins
// [R16] clock outputs stop during suspend
`timescale 1ns/1ps
`default_nettype none
module aux_pin_function_mux
  import aux_mux_pkg::*;
#(
  parameter int WAKE_HOLD = WAKE_CYCLES,  // ring low time before wakeup
  parameter int LED_HOLD  = LED_CYCLES    // activity pulse length
) (
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  // configuration memory image, sampled at cfg_load_i
  input  wire logic                        cfg_load_i,
  input  wire logic [CTRL_PINS*FN_BITS-1:0] cfg_fn_i,
  input  wire logic                        cfg_pull_down_i,
  input  wire logic                        cfg_remote_wake_i,
  // bridge state
  input  wire link_state_t                 link_i,
  input  wire logic                        serial_tx_i,
  input  wire logic                        rts_n_i,
  input  wire logic                        dtr_n_i,
  input  wire logic [CTRL_PINS-1:0]        bitbang_out_i,
  input  wire logic [CTRL_PINS-1:0]        bitbang_dir_i,
  // pins
  input  wire logic [CTRL_PINS-1:0]        control_bus_pin_i,
  output logic      [CTRL_PINS-1:0]        control_bus_pin_o,
  output logic      [CTRL_PINS-1:0]        control_bus_pin_oe_n_o,
  output logic      [CTRL_PINS-1:0]        control_bus_pull_down_o,
  input  wire logic [DATA_PINS-1:0]        data_bus_pin_i,
  output logic      [DATA_PINS-1:0]        data_bus_pin_o,
  output logic      [DATA_PINS-1:0]        data_bus_pin_oe_n_o,
  output logic      [DATA_PINS-1:0]        data_bus_pull_down_o,
  // towards the bridge
  output logic      [CTRL_PINS-1:0]        bitbang_in_o,
  output logic                             serial_rx_o,
  output logic                             cts_n_o,
  output logic                             dsr_n_o,
  output logic                             dcd_n_o,
  output logic                             ring_indicator_n_o,
  output logic                             remote_wake_o
);
  // refuse hold counts that the counters cannot serve
  if (WAKE_HOLD < 1 || LED_HOLD < 1) begin : g_bad_hold
    $error("aux_pin_function_mux: bad hold counts");
  end

  // ---------------- configuration latch ----------------
  pin_fn_t    fn_reg  [CTRL_PINS];  // active function per pin
  pin_fn_t    fn_next [CTRL_PINS];
  logic       pd_reg, pd_next;      // suspend pull-down option
  logic       rw_reg, rw_next;      // remote wakeup option

  // decode with legality: an option a pin cannot carry falls back to pulled-up input
  always_comb begin
    pd_next = pd_reg;
    rw_next = rw_reg;
    for (int p = 0; p < CTRL_PINS; p++) begin
      fn_next[p] = fn_reg[p];
      // [R10] startup configuration load
      if (cfg_load_i) begin
        fn_next[p] = pin_fn_t'(cfg_fn_i[p*FN_BITS +: FN_BITS]);
        case (pin_fn_t'(cfg_fn_i[p*FN_BITS +: FN_BITS]))
          // [R7] clock pins only
          FN_CLK_FAST, FN_CLK_MID, FN_CLK_SLOW: begin
            if (!CLK_PIN_MASK[p]) fn_next[p] = FN_PULLED_UP_INPUT;
          end
          // [R15] drive-high restriction
          FN_DRIVE_HIGH: begin
            if (!CLK_PIN_MASK[p]) fn_next[p] = FN_PULLED_UP_INPUT;
          end
          // [R8] bit-bang pins only
          FN_BITBANG: begin
            if (!BB_PIN_MASK[p]) fn_next[p] = FN_PULLED_UP_INPUT;
          end
          FN_PULLED_UP_INPUT: begin
            fn_next[p] = FN_PULLED_UP_INPUT;
          end
          // [R9] pin 7 excluded
          FN_LINE_DRV_EN, FN_POWER_EN_N, FN_TX_LED_N, FN_RX_LED_N,
          FN_TXRX_LED_N, FN_SUSPEND_N, FN_DRIVE_LOW: begin
            if (!ANY_PIN_MASK[p]) fn_next[p] = FN_PULLED_UP_INPUT;
          end
          default: begin
            fn_next[p] = FN_PULLED_UP_INPUT;
          end
        endcase
      end
    end
    if (cfg_load_i) begin
      pd_next = cfg_pull_down_i;
      rw_next = cfg_remote_wake_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int p = 0; p < CTRL_PINS; p++) fn_reg[p] <= pin_fn_t'(CFG_RESET_FN);
      pd_reg <= 1'b0;
      rw_reg <= 1'b0;
    end else begin
      for (int p = 0; p < CTRL_PINS; p++) fn_reg[p] <= fn_next[p];
      pd_reg <= pd_next;
      rw_reg <= rw_next;
    end
  end

  // ---------------- clock divider ----------------
  // counter bits give clk/2, /4, /8; at 40 MHz these are scaled stand-ins
  logic [2:0] div_reg, div_next;
  always_comb begin
    div_next = div_reg + 3'h1;
    // [R16] clear the divider in suspend so clocks stop low
    if (link_i.suspended) div_next = 3'h0;
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) div_reg <= 3'h0;
    else           div_reg <= div_next;
  end

  // ---------------- activity indicators ----------------
  logic tx_led_n, rx_led_n, txrx_led_n;
  // [R3] transmit pulse
  activity_stretch #(.HOLD(LED_HOLD)) u_tx_led (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .busy_i    (link_i.tx_busy),
    .led_n_o   (tx_led_n)
  );
  // [R4] receive pulse
  activity_stretch #(.HOLD(LED_HOLD)) u_rx_led (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .busy_i    (link_i.rx_busy),
    .led_n_o   (rx_led_n)
  );
  // [R5] either direction
  assign txrx_led_n = tx_led_n & rx_led_n;

  // power enable: low only when configured and not suspended
  logic pwr_en_n;
  // [R2] power enable level
  assign pwr_en_n = !(link_i.configured && !link_i.suspended);

  // ---------------- pin synchronisers ----------------
  logic [CTRL_PINS-1:0] cs1_reg, cs2_reg, cs3_reg, cin_reg;  // control pins
  logic [DATA_PINS-1:0] ds1_reg, ds2_reg, ds3_reg, din_reg;  // data pins
  // a change is taken once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cs1_reg <= '1; cs2_reg <= '1; cs3_reg <= '1; cin_reg <= '1;
      ds1_reg <= '1; ds2_reg <= '1; ds3_reg <= '1; din_reg <= '1;
    end else begin
      cs1_reg <= control_bus_pin_i;
      cs2_reg <= cs1_reg;
      cs3_reg <= cs2_reg;
      cin_reg <= (cin_reg & (cs2_reg ^ cs3_reg)) | (cs3_reg & ~(cs2_reg ^ cs3_reg));
      ds1_reg <= data_bus_pin_i;
      ds2_reg <= ds1_reg;
      ds3_reg <= ds2_reg;
      din_reg <= (din_reg & (ds2_reg ^ ds3_reg)) | (ds3_reg & ~(ds2_reg ^ ds3_reg));
    end
  end

  // ---------------- control pin drive ----------------
  generate
    for (genvar p = 0; p < CTRL_PINS; p++) begin : g_pin
      pin_drive_t drv;
      always_comb begin
        drv.out       = 1'b0;
        drv.oe_n      = 1'b1;
        // [R13] suspend pull-down on inputs
        drv.pull_down = pd_reg && pwr_en_n;
        case (fn_reg[p])
          // [R1] guarded frame window
          FN_LINE_DRV_EN: begin drv.out = link_i.tx_guard; drv.oe_n = 1'b0; end
          FN_POWER_EN_N:  begin drv.out = pwr_en_n;        drv.oe_n = 1'b0; end
          FN_TX_LED_N:    begin drv.out = tx_led_n;        drv.oe_n = 1'b0; end
          FN_RX_LED_N:    begin drv.out = rx_led_n;        drv.oe_n = 1'b0; end
          FN_TXRX_LED_N:  begin drv.out = txrx_led_n;      drv.oe_n = 1'b0; end
          // [R6] suspend indicator
          FN_SUSPEND_N:   begin drv.out = !link_i.suspended; drv.oe_n = 1'b0; end
          // [R7] divided clocks
          FN_CLK_FAST:    begin drv.out = div_reg[0];      drv.oe_n = 1'b0; end
          FN_CLK_MID:     begin drv.out = div_reg[1];      drv.oe_n = 1'b0; end
          FN_CLK_SLOW:    begin drv.out = div_reg[2];      drv.oe_n = 1'b0; end
          // [R15] fixed levels
          FN_DRIVE_HIGH:  begin drv.out = 1'b1;            drv.oe_n = 1'b0; end
          FN_DRIVE_LOW:   begin drv.out = 1'b0;            drv.oe_n = 1'b0; end
          // [R8] software-owned level and direction
          FN_BITBANG: begin
            drv.out  = bitbang_out_i[p];
            drv.oe_n = !bitbang_dir_i[p];
          end
          default: begin drv.out = 1'b0; drv.oe_n = 1'b1; end
        endcase
        if (!drv.oe_n) drv.pull_down = 1'b0;
      end
      assign control_bus_pin_o[p]       = drv.out;
      assign control_bus_pin_oe_n_o[p]  = drv.oe_n;
      assign control_bus_pull_down_o[p] = drv.pull_down;
      assign bitbang_in_o[p] = (fn_reg[p] == FN_BITBANG) ? cin_reg[p] : 1'b0;
    end
  endgenerate

  // ---------------- data bus serial port ----------------
  // [R11] default serial roles
  assign data_bus_pin_o       = {3'h0, dtr_n_i, 1'b0, rts_n_i, 1'b0, serial_tx_i};
  // only pins 0, 2 and 4 drive; cts on pin 3 must stay an input
  assign data_bus_pin_oe_n_o  = 8'hea;
  assign data_bus_pull_down_o = {8{pd_reg && pwr_en_n}} & 8'hea;
  assign serial_rx_o          = din_reg[1];
  assign cts_n_o              = din_reg[3];
  assign dsr_n_o              = din_reg[5];
  assign dcd_n_o              = din_reg[6];
  assign ring_indicator_n_o   = din_reg[7];

  // ---------------- ring indicator wakeup ----------------
  logic [31:0] ring_cnt_reg, ring_cnt_next;  // ring low duration
  logic        wake_reg, wake_next;          // resume request level
  always_comb begin
    ring_cnt_next = 32'h0;
    wake_next     = 1'b0;
    // [R12] ring held low past limit
    if (rw_reg && link_i.suspended && !din_reg[7]) begin
      ring_cnt_next = (ring_cnt_reg == 32'(WAKE_HOLD)) ? ring_cnt_reg : ring_cnt_reg + 32'h1;
      wake_next     = (ring_cnt_reg == 32'(WAKE_HOLD));
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ring_cnt_reg <= 32'h0;
      wake_reg     <= 1'b0;
    end else begin
      ring_cnt_reg <= ring_cnt_next;
      wake_reg     <= wake_next;
    end
  end
  assign remote_wake_o = wake_reg;
endmodule // aux_pin_function_mux
`default_nettype wire

//--- sim/aux_mux_properties.sv
// assertion checker for the pin function multiplexer, with its bind
`timescale 1ns/1ps
`default_nettype none
module aux_mux_properties
  import aux_mux_pkg::*;
#(
  parameter int WAKE_HOLD = WAKE_CYCLES,  // ring low time
  parameter int LED_HOLD  = LED_CYCLES    // led pulse time
) (
  input wire logic                         clk_i,
  input wire logic                         sys_rst_i,
  input wire logic                         cfg_load_i,
  input wire logic [CTRL_PINS*FN_BITS-1:0] cfg_fn_i,
  input wire logic                         cfg_pull_down_i,
  input wire link_state_t                  link_i,
  input wire logic [DATA_PINS-1:0]         data_bus_pin_i,
  input wire logic [CTRL_PINS-1:0]         control_bus_pin_o,
  input wire logic [CTRL_PINS-1:0]         control_bus_pin_oe_n_o,
  input wire logic [CTRL_PINS-1:0]         control_bus_pull_down_o,
  input wire logic [DATA_PINS-1:0]         data_bus_pin_oe_n_o,
  input wire logic                         remote_wake_o
);
  logic [3:0] fn_reg, fn_next;  // pin 0 function as loaded
  logic       pd_reg, pd_next;  // pull-down option as loaded
  wire logic  o0 = control_bus_pin_o[0];
  wire logic  e0 = control_bus_pin_oe_n_o[0];
  // shadow of pin 0 setup; codes past drive-low are refused on pin 0
  always_comb begin
    fn_next = fn_reg;
    pd_next = pd_reg;
    if (cfg_load_i) begin
      fn_next = (cfg_fn_i[3:0] > 4'hb) ? 4'h0 : cfg_fn_i[3:0];
      pd_next = cfg_pull_down_i;
    end
  end
  // register the shadow
  always_ff @(posedge clk_i) begin
    fn_reg <= sys_rst_i ? 4'h0 : fn_next;
    pd_reg <= sys_rst_i ? 1'b0 : pd_next;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // three samples cover a registered copy of the link state
  sequence s_susp; link_i.suspended [*3]; endsequence
  sequence s_awake; (link_i.configured && !link_i.suspended) [*2]; endsequence
  sequence s_tx; fn_reg == 4'h3 && link_i.tx_busy ##1 fn_reg == 4'h3; endsequence
  AST_PIN7: assert property (control_bus_pin_oe_n_o[7])
    else $error("pin 7 driven");
  AST_DATA_DIR: assert property (data_bus_pin_oe_n_o == 8'hea)
    else $error("data pin direction wrong");
  AST_DRIVE: assert property (fn_reg inside {4'ha, 4'hb} |-> !e0 && o0 == (fn_reg == 4'ha))
    else $error("fixed level wrong");
  AST_PULLUP: assert property (fn_reg == 4'h0 |-> e0)
    else $error("input pin driven");
  AST_PWR: assert property (s_awake ##0 fn_reg == 4'h2 |-> !e0 && !o0)
    else $error("power enable not low");
  AST_LINE_DRIVER_ENABLE_IDLE: assert property ((fn_reg == 4'h1 && !link_i.tx_guard) [*2] |-> !e0 && !o0)
    else $error("driver enable outside frame");
  AST_CLK: assert property ((fn_reg == 4'h7 && !link_i.suspended) [*3] |-> !e0 && o0 != $past(o0))
    else $error("clock output stuck");
  AST_CLK_STOP: assert property (s_susp ##0 fn_reg inside {4'h7, 4'h8, 4'h9} |-> !o0)
    else $error("clock runs in suspend");
  AST_LED: assert property (s_tx |-> !o0)
    else $error("tx led not low");
  AST_WAKE: assert property (data_bus_pin_i[7] [*8] |-> !remote_wake_o)
    else $error("wake without ring");
  AST_PD: assert property (control_bus_pull_down_o != '0 |->
                           pd_reg && (control_bus_pull_down_o & ~control_bus_pin_oe_n_o) == '0)
    else $error("pull-down misplaced");
endmodule // aux_mux_properties
bind aux_pin_function_mux aux_mux_properties #(.WAKE_HOLD(WAKE_HOLD), .LED_HOLD(LED_HOLD)) chk_u (
  .clk_i, .sys_rst_i, .cfg_load_i, .cfg_fn_i, .cfg_pull_down_i, .link_i, .data_bus_pin_i,
  .control_bus_pin_o, .control_bus_pin_oe_n_o, .control_bus_pull_down_o, .data_bus_pin_oe_n_o,
  .remote_wake_o);
`default_nettype wire

//--- sim/ext_logic_model.sv
// far side: converters and loads that settle each pin's level
`timescale 1ns/1ps
`default_nettype none
module ext_logic_model (
  input  wire logic [9:0] c_out_i,   // device drive, control pins
  input  wire logic [9:0] c_oe_n_i,  // low while device drives
  input  wire logic [9:0] c_pd_i,    // device weak pull-down
  input  wire logic [7:0] d_out_i,   // device drive, data pins
  input  wire logic [7:0] d_oe_n_i,  // low while device drives
  input  wire logic [7:0] d_far_i,   // far-side levels on input pins
  output logic      [9:0] c_lvl_o,   // settled control pin level
  output logic      [7:0] d_lvl_o    // settled data pin level
);
  // control loads never drive, so a released control pin floats to its weak pull; released data pins take d_far_i
  assign c_lvl_o = (~c_oe_n_i & c_out_i) | (c_oe_n_i & ~c_pd_i);
  assign d_lvl_o = (~d_oe_n_i & d_out_i) | (d_oe_n_i & d_far_i);
endmodule // ext_logic_model
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb import aux_mux_pkg::*;;
  localparam int LH = 4;   // short led pulse keeps the run brief
  localparam int WH = 10;  // short wake delay
  logic        clk_i = 0, sys_rst_i = 1, cfg_load_i = 0, cfg_pull_down_i = 0;
  logic        cfg_remote_wake_i = 0, serial_tx_i = 1, rts_n_i = 1, dtr_n_i = 1;
  logic [39:0] cfg_fn_i = '0;  // function per pin
  link_state_t link_i = '0;    // bridge state
  logic [9:0]  bb_out = '0, bb_dir = '0, c_lvl, c_out, c_oe, c_pd, bb_in;
  logic [7:0]  d_far = 8'hff, d_lvl, d_out, d_oe, d_pd;
  logic        rx, cts, dsr, dcd, ri, wake, lv;
  int          n_fail = 0, checks = 0, cyc = 0, e, tg;
  always #12.5 clk_i = ~clk_i;
  aux_pin_function_mux #(.WAKE_HOLD(WH), .LED_HOLD(LH)) dut_u (
    .clk_i, .sys_rst_i, .cfg_load_i, .cfg_fn_i, .cfg_pull_down_i, .cfg_remote_wake_i,
    .link_i, .serial_tx_i, .rts_n_i, .dtr_n_i, .bitbang_out_i(bb_out), .bitbang_dir_i(bb_dir),
    .control_bus_pin_i(c_lvl), .control_bus_pin_o(c_out), .control_bus_pin_oe_n_o(c_oe),
    .control_bus_pull_down_o(c_pd), .data_bus_pin_i(d_lvl), .data_bus_pin_o(d_out),
    .data_bus_pin_oe_n_o(d_oe), .data_bus_pull_down_o(d_pd), .bitbang_in_o(bb_in),
    .serial_rx_o(rx), .cts_n_o(cts), .dsr_n_o(dsr), .dcd_n_o(dcd),
    .ring_indicator_n_o(ri), .remote_wake_o(wake));
  ext_logic_model far_u (.c_out_i(c_out), .c_oe_n_i(c_oe), .c_pd_i(c_pd), .d_out_i(d_out),
    .d_oe_n_i(d_oe), .d_far_i(d_far), .c_lvl_o(c_lvl), .d_lvl_o(d_lvl));
  task automatic close_out();
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle load strobe for a configuration image
  task automatic load(input logic [39:0] f, input logic pd, input logic wk);
    @(posedge clk_i);
    cfg_fn_i <= f;
    cfg_pull_down_i <= pd;
    cfg_remote_wake_i <= wk;
    cfg_load_i <= 1'b1;
    @(posedge clk_i);
    cfg_load_i <= 1'b0;
  endtask
  // whether pin p accepts function c; code 0 (pulled-up input) gives 0
  function automatic logic legal(int p, logic [3:0] c);
    if (c inside {4'h7, 4'h8, 4'h9, 4'ha}) return p inside {0, 5, 6, 8, 9};
    if (c == 4'hc) return p inside {5, 6, 8, 9};
    return c != 4'h0 && c < 4'hc && p != 7;
  endfunction
  // cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    e = $urandom(32'hfed5bbfa);
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    link_i.configured <= 1'b1;
    @(negedge clk_i);
    chk(c_oe, 10'h3ff);
    // every code on every pin, refused ones too
    for (int p = 0; p < 10; p++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge clk_i);
        bb_out <= 10'($urandom);
        bb_dir <= 10'($urandom);
        load(40'(c) << (4 * p), 1'b0, 1'b0);
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        e = legal(p, 4'(c)) && (c != 12 || bb_dir[p]);
        chk(c_oe[p], !e);
        if (e && c inside {10, 11, 12}) chk(c_out[p], c == 10 || (c == 12 && bb_out[p]));
        if (c == 12 && legal(p, 4'hc)) chk(bb_in[p], !bb_dir[p] || bb_out[p]);
        // count edges over eight cycles: /2, /4, /8 give 8, 4, 2
        if (e && c inside {7, 8, 9}) begin
          tg = 0;
          repeat (8) begin
            lv = c_out[p];
            @(negedge clk_i);
            tg += (c_out[p] != lv);
          end
          chk(tg, 8 >> (c - 7));
        end
      end
    end
    // serial roles of the data pins
    repeat (8) begin
      @(posedge clk_i);
      {serial_tx_i, rts_n_i, dtr_n_i} <= 3'($urandom);
      d_far <= 8'($urandom);
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      chk(d_oe, 8'hea);
      chk({d_out[4], d_out[2], d_out[0]}, {dtr_n_i, rts_n_i, serial_tx_i});
      chk({ri, dcd, dsr, cts, rx}, {d_far[7:5], d_far[3], d_far[1]});
    end
    // one-cycle bursts, led held then released
    load(40'h543, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      link_i.tx_busy <= !k[0];
      link_i.rx_busy <= k[0];
      @(posedge clk_i);
      link_i.tx_busy <= 1'b0;
      link_i.rx_busy <= 1'b0;
      repeat (LH - 1) @(posedge clk_i);
      @(negedge clk_i);
      chk(c_out[2:0], {1'b0, !k[0], k[0]});
      repeat (LH + 3) @(posedge clk_i);
      @(negedge clk_i);
      chk(c_out[2:0], 3'h7);
    end
    // pull-down option used with power enable
    load(40'h600127, 1'b1, 1'b1);
    @(posedge clk_i);
    link_i.suspended <= 1'b1;
    d_far[7] <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk({c_out[5], c_out[1:0], c_pd[3], wake}, 5'b01010);
    chk(d_pd, 8'hea);
    repeat (WH + 8) @(posedge clk_i);
    @(negedge clk_i);
    chk(wake, 1'b1);
    @(posedge clk_i);
    link_i.suspended <= 1'b0;
    link_i.tx_guard <= 1'b1;
    d_far[7] <= 1'b1;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk({c_out[5], c_out[2:1], c_pd[3], wake}, 5'b11000);
    chk(d_pd, 8'h00);
    // a second reset drops every loaded function
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk(c_oe, 10'h3ff);
    close_out();
  end
endmodule // tb
`default_nettype wire
